//--- prd_paged_register_decode.sv
/*
 * Host-side register decoder with four pages of byte-wide registers.
 * Assumes the host strobes are synchronous to mclk_i, one cycle wide, and
 * that the controller core drives the live status struct from mclk_i.
 */
// Overview of operation
// - Every register is one byte; each host access moves eight bits.
// - Four pages, chosen by the two page-select bits of the command register.
// - Four index lines pick one of sixteen locations inside the page.
// - Page codes: 0 normal, low bit 1 init, high bit 2 diagnostics.
// - Page 0 reads 01H/02H give local DMA; writes load ring bounds.
// - Page 2 reverses it: reads give ring bounds, writes load local DMA.
// - Page 2 0CH-0FH read back config and mask; writes there ignored.
// - Page 2 location 03H reads and writes the remote next-frame pointer.
// - Page 1 location 07H reads and writes the receive write-page register.
// - Page 1 holds six station bytes at 01H-06H, eight hash bytes at 08H.
`timescale 1ns/1ps
`include "prd_defs.svh"

module prd_paged_register_decode #(
  parameter int STATION_BYTES = 6,
  parameter int HASH_BYTES = 8
) (
  input wire logic mclk_i, // System clock, 100 MHz.
  input wire logic reset_n_i, // Asynchronous reset, active low.
  input wire logic host_rd_i, // Host read strobe, one cycle.
  input wire logic host_wr_i, // Host write strobe, one cycle.
  input wire logic [3:0] reg_index_lines_i, // Location within the page.
  input wire logic [7:0] host_wdata_i, // Host write byte.
  input wire prd_pkg::prd_core_stat_t core_i, // Live core values.
  output logic [7:0] host_rdata_o, // Read byte, held until next read.
  output logic host_rvalid_o, // Read byte valid, one cycle.
  output prd_pkg::prd_cfg_t cfg_o, // Stored registers to the core.
  output logic [STATION_BYTES*8-1:0] station_addr_bytes_o, // Station addr.
  output logic [HASH_BYTES*8-1:0] multicast_hash_bytes_o // Hash filter.
);

  // Stored state. The command, interrupt status and local DMA position
  // have update rules of their own; every other host register is a plain
  // byte in the bank, found through the slot numbers of the defines.
  logic [7:0] command_register_r;
  logic [7:0] irq_status_r;
  logic [7:0] irq_status_nxt;
  logic [7:0] local_dma_pos_lo_r;
  logic [7:0] local_dma_pos_hi_r;
  logic [7:0] bank_r [0:`PRD_SLOTS-1];
  logic [`PRD_SLOTS-1:0] bank_we;
  logic [7:0] rdata_nxt;
  logic [7:0] host_rdata_r;
  logic host_rvalid_r;

  // Decode wires: the page, the per-page write qualifiers and the special
  // enables whose targets do not live in the plain bank.
  wire [1:0] page_sel;
  wire wr_p0;
  wire wr_p1;
  wire wr_p2;
  wire rd_p0;
  wire rd_p1;
  wire rd_p2;
  wire wr_cmd;
  wire wr_irq_clr;
  wire wr_ldma_lo;
  wire wr_ldma_hi;

  // page from command bits
  // The page is taken from the stored command bits, so a new page only
  // applies from the access after the command write has landed.
  assign page_sel = {command_register_r[`PRD_CMD_PS_HI],
                     command_register_r[`PRD_CMD_PS_LO]};

  // page 3 writes dropped
  // Page 3 has no storage; writes there fall through every enable below except the command's.
  assign wr_p0 = host_wr_i && (page_sel == `PRD_PAGE0);
  assign wr_p1 = host_wr_i && (page_sel == `PRD_PAGE1);
  assign wr_p2 = host_wr_i && (page_sel == `PRD_PAGE2);
  // Read page flags carry no strobe; the read path is qualified later by
  // host_rd_i, at the point where the answer byte is captured.
  assign rd_p0 = page_sel == `PRD_PAGE0;
  assign rd_p1 = page_sel == `PRD_PAGE1;
  assign rd_p2 = page_sel == `PRD_PAGE2;

  // command in every page
  // The command stays writable even in page 3 so software can always get
  // back out of a page it selected by mistake.
  assign wr_cmd = host_wr_i && (reg_index_lines_i == `PRD_LOC_CMD);

  // Page 0 write enables of the plain storage bank.
  // Locations 01H and 02H land in the ring bounds here, not in the local
  // DMA position that they read back; page 2 swaps the two roles, so both
  // sides stay reachable for diagnostics.
  // page 0 writes ring bounds
  assign bank_we[`PRD_SLOT_RING_FIRST] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_01);
  assign bank_we[`PRD_SLOT_RING_LAST] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_02);
  assign bank_we[`PRD_SLOT_BOUNDARY] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_03);
  assign bank_we[`PRD_SLOT_TX_FIRST] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_04);
  assign bank_we[`PRD_SLOT_TX_LEN_LO] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_05);
  assign bank_we[`PRD_SLOT_TX_LEN_HI] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_06);
  assign bank_we[`PRD_SLOT_RFIRST_LO] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_08);
  assign bank_we[`PRD_SLOT_RFIRST_HI] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_09);
  assign bank_we[`PRD_SLOT_RLEN_LO] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_0A);
  assign bank_we[`PRD_SLOT_RLEN_HI] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_0B);
  assign bank_we[`PRD_SLOT_RX_CFG] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_0C);
  assign bank_we[`PRD_SLOT_TX_CFG] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_0D);
  assign bank_we[`PRD_SLOT_DATA_CFG] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_0E);
  assign bank_we[`PRD_SLOT_IRQ_MASK] =
    wr_p0 && (reg_index_lines_i == `PRD_LOC_0F);

  // Page 1 and page 2 write enables.
  // Page 2 locations 04H and 08H-0FH have no enable at all, so writes
  // there are dropped and leave no trace.
  // page 1 write page
  assign bank_we[`PRD_SLOT_RX_WPAGE] =
    wr_p1 && (reg_index_lines_i == `PRD_LOC_07);
  assign bank_we[`PRD_SLOT_RNEXT] =
    wr_p2 && (reg_index_lines_i == `PRD_LOC_03);
  assign bank_we[`PRD_SLOT_LNEXT] =
    wr_p2 && (reg_index_lines_i == `PRD_LOC_05);
  assign bank_we[`PRD_SLOT_ACNT_HI] =
    wr_p2 && (reg_index_lines_i == `PRD_LOC_06);
  assign bank_we[`PRD_SLOT_ACNT_LO] =
    wr_p2 && (reg_index_lines_i == `PRD_LOC_07);

  // station and hash enables
  // One enable per byte; the byte's location is its base plus its number.
  genvar g;
  generate
    for (g = 0; g < STATION_BYTES; g = g + 1) begin : g_station_we
      assign bank_we[`PRD_SLOT_STATION + g] = wr_p1 &&
        (reg_index_lines_i == (`PRD_LOC_STATION_BASE + 4'(g)));
    end
    for (g = 0; g < HASH_BYTES; g = g + 1) begin : g_hash_we
      assign bank_we[`PRD_SLOT_HASH + g] = wr_p1 &&
        (reg_index_lines_i == (`PRD_LOC_HASH_BASE + 4'(g)));
    end
  endgenerate

  // Interrupt status clear and local DMA load enables.
  // The page 0 status location is write-one-to-clear: the byte written is
  // a mask of bits to drop, never a new value.
  assign wr_irq_clr = wr_p0 && (reg_index_lines_i == `PRD_LOC_07);
  assign wr_ldma_lo = wr_p2 && (reg_index_lines_i == `PRD_LOC_01);
  assign wr_ldma_hi = wr_p2 && (reg_index_lines_i == `PRD_LOC_02);

  // byte-wide storage bank
  // Each slot is a plain byte loaded only by its own write enable, so a
  // read can never alter it.
  generate
    for (g = 0; g < `PRD_SLOTS; g = g + 1) begin : g_bank
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          bank_r[g] <= `PRD_BYTE_RESET;
        end else if (bank_we[g]) begin
          bank_r[g] <= host_wdata_i;
        end
      end
    end
  endgenerate

  // Command register, writable from any page.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      command_register_r <= `PRD_CMD_RESET;
    end else if (wr_cmd) begin
      command_register_r <= host_wdata_i;
    end
  end

  // A core event in the same cycle as a host clear survives: the set term
  // is applied after the clear term.
  assign irq_status_nxt = wr_irq_clr ?
    ((irq_status_r & ~host_wdata_i) | core_i.irq_set) :
    (irq_status_r | core_i.irq_set);

  // Interrupt status: core sets bits, host writes ones to clear them.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_status_r <= `PRD_BYTE_RESET;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // Local DMA position: the core's own update outranks a diagnostic write,
  // since the running DMA must not lose its place. A page 0 write to 01H
  // or 02H goes to the ring bounds and never reaches these bytes.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      local_dma_pos_lo_r <= `PRD_BYTE_RESET;
      local_dma_pos_hi_r <= `PRD_BYTE_RESET;
    end else if (core_i.local_dma_load) begin
      local_dma_pos_lo_r <= core_i.local_dma_lo;
      local_dma_pos_hi_r <= core_i.local_dma_hi;
    end else begin
      if (wr_ldma_lo) begin
        local_dma_pos_lo_r <= host_wdata_i;
      end
      if (wr_ldma_hi) begin
        local_dma_pos_hi_r <= host_wdata_i;
      end
    end
  end

  // read location select
  // Read selection per page; reserved locations and page 3 apart from the command location give
  // zero and touch nothing.
  // Page 3 has no branch of its own and falls through to the zero.
  always_comb begin
    rdata_nxt = `PRD_BYTE_RESET;
    if (reg_index_lines_i == `PRD_LOC_CMD) begin
      rdata_nxt = command_register_r;
    end else if (rd_p0) begin
      case (reg_index_lines_i)
        `PRD_LOC_01: rdata_nxt = local_dma_pos_lo_r;
        `PRD_LOC_02: rdata_nxt = local_dma_pos_hi_r;
        `PRD_LOC_03: rdata_nxt = bank_r[`PRD_SLOT_BOUNDARY];
        `PRD_LOC_04: rdata_nxt = core_i.tx_status;
        `PRD_LOC_05: rdata_nxt = core_i.collision_tally;
        `PRD_LOC_06: rdata_nxt = core_i.fifo_peek;
        `PRD_LOC_07: rdata_nxt = irq_status_r;
        `PRD_LOC_08: rdata_nxt = core_i.remote_dma_pos_lo;
        `PRD_LOC_09: rdata_nxt = core_i.remote_dma_pos_hi;
        `PRD_LOC_0C: rdata_nxt = core_i.rx_status;
        `PRD_LOC_0D: rdata_nxt = core_i.align_error_tally;
        `PRD_LOC_0E: rdata_nxt = core_i.checksum_error_tally;
        `PRD_LOC_0F: rdata_nxt = core_i.missed_frame_tally;
        default: rdata_nxt = `PRD_BYTE_RESET;
      endcase
    end else if (rd_p1) begin
      // Page 1 is flat: 07H is the write page, the rest split at the base.
      // station and hash reads
      if (reg_index_lines_i == `PRD_LOC_07) begin
        rdata_nxt = bank_r[`PRD_SLOT_RX_WPAGE];
      end else if (reg_index_lines_i >= `PRD_LOC_HASH_BASE) begin
        rdata_nxt = bank_r[`PRD_SLOT_HASH +
          int'(reg_index_lines_i - `PRD_LOC_HASH_BASE)];
      end else begin
        rdata_nxt = bank_r[`PRD_SLOT_STATION +
          int'(reg_index_lines_i - `PRD_LOC_STATION_BASE)];
      end
    end else if (rd_p2) begin
      // Page 2 reads back page 0 bytes at 01H, 02H, 04H and 0CH-0FH, and its own bytes at 03H and 05H-07H.
      case (reg_index_lines_i)
        `PRD_LOC_01: rdata_nxt = bank_r[`PRD_SLOT_RING_FIRST];
        `PRD_LOC_02: rdata_nxt = bank_r[`PRD_SLOT_RING_LAST];
        `PRD_LOC_03: rdata_nxt = bank_r[`PRD_SLOT_RNEXT];
        `PRD_LOC_04: rdata_nxt = bank_r[`PRD_SLOT_TX_FIRST];
        `PRD_LOC_05: rdata_nxt = bank_r[`PRD_SLOT_LNEXT];
        `PRD_LOC_06: rdata_nxt = bank_r[`PRD_SLOT_ACNT_HI];
        `PRD_LOC_07: rdata_nxt = bank_r[`PRD_SLOT_ACNT_LO];
        `PRD_LOC_0C: rdata_nxt = bank_r[`PRD_SLOT_RX_CFG];
        `PRD_LOC_0D: rdata_nxt = bank_r[`PRD_SLOT_TX_CFG];
        `PRD_LOC_0E: rdata_nxt = bank_r[`PRD_SLOT_DATA_CFG];
        `PRD_LOC_0F: rdata_nxt = bank_r[`PRD_SLOT_IRQ_MASK];
        default: rdata_nxt = `PRD_BYTE_RESET;
      endcase
    end
  end

  // Read answer: the byte is captured on the read strobe and held, so a
  // slow host may sample it any time before its next read. A write in the
  // same cycle still lands; the read returns the byte from before it.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_rdata_r <= `PRD_BYTE_RESET;
      host_rvalid_r <= 1'b0;
    end else begin
      host_rvalid_r <= host_rd_i;
      if (host_rd_i) begin
        host_rdata_r <= rdata_nxt;
      end
    end
  end

  assign host_rdata_o = host_rdata_r;
  assign host_rvalid_o = host_rvalid_r;

  // Stored registers handed to the core, all straight from flops.
  // Nothing here depends on the page, so a page change never disturbs
  // what the core sees.
  assign cfg_o.command_register = command_register_r;
  assign cfg_o.ring_first_page = bank_r[`PRD_SLOT_RING_FIRST];
  assign cfg_o.ring_last_page = bank_r[`PRD_SLOT_RING_LAST];
  assign cfg_o.ring_read_boundary = bank_r[`PRD_SLOT_BOUNDARY];
  assign cfg_o.tx_first_page = bank_r[`PRD_SLOT_TX_FIRST];
  assign cfg_o.tx_length_lo = bank_r[`PRD_SLOT_TX_LEN_LO];
  assign cfg_o.tx_length_hi = bank_r[`PRD_SLOT_TX_LEN_HI];
  assign cfg_o.remote_first_addr_lo = bank_r[`PRD_SLOT_RFIRST_LO];
  assign cfg_o.remote_first_addr_hi = bank_r[`PRD_SLOT_RFIRST_HI];
  assign cfg_o.remote_length_lo = bank_r[`PRD_SLOT_RLEN_LO];
  assign cfg_o.remote_length_hi = bank_r[`PRD_SLOT_RLEN_HI];
  assign cfg_o.rx_config = bank_r[`PRD_SLOT_RX_CFG];
  assign cfg_o.tx_config = bank_r[`PRD_SLOT_TX_CFG];
  assign cfg_o.data_config = bank_r[`PRD_SLOT_DATA_CFG];
  assign cfg_o.irq_mask = bank_r[`PRD_SLOT_IRQ_MASK];
  assign cfg_o.irq_status = irq_status_r;
  assign cfg_o.rx_write_page = bank_r[`PRD_SLOT_RX_WPAGE];
  assign cfg_o.remote_next_frame_ptr = bank_r[`PRD_SLOT_RNEXT];
  assign cfg_o.local_next_frame_ptr = bank_r[`PRD_SLOT_LNEXT];
  assign cfg_o.addr_counter_hi = bank_r[`PRD_SLOT_ACNT_HI];
  assign cfg_o.addr_counter_lo = bank_r[`PRD_SLOT_ACNT_LO];
  assign cfg_o.local_dma_pos_lo = local_dma_pos_lo_r;
  assign cfg_o.local_dma_pos_hi = local_dma_pos_hi_r;

  // Station address and hash filter bytes, byte 0 in the low lane.
  // The address filter reads these lanes directly, without any decoding.
  generate
    for (g = 0; g < STATION_BYTES; g = g + 1) begin : g_station_out
      assign station_addr_bytes_o[g*8 +: 8] = bank_r[`PRD_SLOT_STATION + g];
    end
    for (g = 0; g < HASH_BYTES; g = g + 1) begin : g_hash_out
      assign multicast_hash_bytes_o[g*8 +: 8] = bank_r[`PRD_SLOT_HASH + g];
    end
  endgenerate

endmodule

//--- prd_defs.svh
/*
 * Register locations, page codes, field positions and reset values of the
 * paged register decoder.
 * Assumes it is included by bare name wherever these names are used.
 */
`ifndef PRD_DEFS_SVH
`define PRD_DEFS_SVH

// Page codes carried in the command register.
`define PRD_PAGE0 2'h0
`define PRD_PAGE1 2'h1
`define PRD_PAGE2 2'h2
`define PRD_PAGE3 2'h3

// Page-select field of the command register.
`define PRD_CMD_PS_HI 7
`define PRD_CMD_PS_LO 6

// Locations within a page.
`define PRD_LOC_CMD 4'h0
`define PRD_LOC_01 4'h1
`define PRD_LOC_02 4'h2
`define PRD_LOC_03 4'h3
`define PRD_LOC_04 4'h4
`define PRD_LOC_05 4'h5
`define PRD_LOC_06 4'h6
`define PRD_LOC_07 4'h7
`define PRD_LOC_08 4'h8
`define PRD_LOC_09 4'h9
`define PRD_LOC_0A 4'ha
`define PRD_LOC_0B 4'hb
`define PRD_LOC_0C 4'hc
`define PRD_LOC_0D 4'hd
`define PRD_LOC_0E 4'he
`define PRD_LOC_0F 4'hf

// First location of the station address and multicast filter groups.
`define PRD_LOC_STATION_BASE 4'h1
`define PRD_LOC_HASH_BASE 4'h8

// Reset values: stop bit high, everything else clear.
`define PRD_CMD_RESET 8'h01
`define PRD_BYTE_RESET 8'h00

// Slots of the plain storage bank.
`define PRD_SLOT_RING_FIRST 0
`define PRD_SLOT_RING_LAST 1
`define PRD_SLOT_BOUNDARY 2
`define PRD_SLOT_TX_FIRST 3
`define PRD_SLOT_TX_LEN_LO 4
`define PRD_SLOT_TX_LEN_HI 5
`define PRD_SLOT_RFIRST_LO 6
`define PRD_SLOT_RFIRST_HI 7
`define PRD_SLOT_RLEN_LO 8
`define PRD_SLOT_RLEN_HI 9
`define PRD_SLOT_RX_CFG 10
`define PRD_SLOT_TX_CFG 11
`define PRD_SLOT_DATA_CFG 12
`define PRD_SLOT_IRQ_MASK 13
`define PRD_SLOT_RX_WPAGE 14
`define PRD_SLOT_RNEXT 15
`define PRD_SLOT_LNEXT 16
`define PRD_SLOT_ACNT_HI 17
`define PRD_SLOT_ACNT_LO 18
`define PRD_SLOT_STATION 19
`define PRD_SLOT_HASH 25
`define PRD_SLOTS 33

`endif

//--- prd_pkg.sv
/*
 * Types shared by the paged register decoder and its neighbours.
 * Assumes prd_defs.svh supplies the numeric constants.
 */
package prd_pkg;

  // Live values that the controller core presents for host reads.
  typedef struct packed {
    logic [7:0] tx_status;
    logic [7:0] collision_tally;
    logic [7:0] fifo_peek;
    logic [7:0] remote_dma_pos_lo;
    logic [7:0] remote_dma_pos_hi;
    logic [7:0] rx_status;
    logic [7:0] align_error_tally;
    logic [7:0] checksum_error_tally;
    logic [7:0] missed_frame_tally;
    logic [7:0] irq_set;
    logic local_dma_load;
    logic [7:0] local_dma_lo;
    logic [7:0] local_dma_hi;
  } prd_core_stat_t;

  // Stored values that the decoder hands to the controller core.
  typedef struct packed {
    logic [7:0] command_register;
    logic [7:0] ring_first_page;
    logic [7:0] ring_last_page;
    logic [7:0] ring_read_boundary;
    logic [7:0] tx_first_page;
    logic [7:0] tx_length_lo;
    logic [7:0] tx_length_hi;
    logic [7:0] remote_first_addr_lo;
    logic [7:0] remote_first_addr_hi;
    logic [7:0] remote_length_lo;
    logic [7:0] remote_length_hi;
    logic [7:0] rx_config;
    logic [7:0] tx_config;
    logic [7:0] data_config;
    logic [7:0] irq_mask;
    logic [7:0] irq_status;
    logic [7:0] rx_write_page;
    logic [7:0] remote_next_frame_ptr;
    logic [7:0] local_next_frame_ptr;
    logic [7:0] addr_counter_hi;
    logic [7:0] addr_counter_lo;
    logic [7:0] local_dma_pos_lo;
    logic [7:0] local_dma_pos_hi;
  } prd_cfg_t;

endpackage

//--- prd_paged_register_decode_props.sv
/*
 * Concurrent checks on the paged register decoder's ports.
 * Assumes one clock and the stored page in command_register[7:6].
 */
`timescale 1ns/1ps
module prd_paged_register_decode_props #(
  parameter int HASH_BYTES = 8
) (
  input wire logic mclk_i, // Clock.
  input wire logic reset_n_i, // Reset, active low.
  input wire logic host_rd_i, // Read strobe.
  input wire logic host_wr_i, // Write strobe.
  input wire logic [3:0] reg_index_lines_i, // Location.
  input wire logic [7:0] host_wdata_i, // Write byte.
  input wire prd_pkg::prd_core_stat_t core_i, // Core values.
  input wire logic [7:0] host_rdata_o, // Read byte.
  input wire logic host_rvalid_o, // Read valid.
  input wire prd_pkg::prd_cfg_t cfg_o, // Stored registers.
  input wire logic [HASH_BYTES*8-1:0] multicast_hash_bytes_o // Hash.
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Page and location joined, so one compare names a page slot.
  wire [1:0] pg = cfg_o.command_register[7:6];
  wire [5:0] sel = {pg, reg_index_lines_i};
  wire rd_only = host_rd_i && !host_wr_i;
  wire quiet = (core_i.irq_set == 8'h00) && !core_i.local_dma_load;

  property p_rd_lat;
    host_rd_i |=> host_rvalid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
  property p_no_spur;
    !host_rd_i |=> !host_rvalid_o && $stable(host_rdata_o);
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("spurious read");
  property p_ring;
    host_wr_i && sel == 6'h02 |=> cfg_o.ring_last_page == $past(host_wdata_i);
  endproperty
  a_ring: assert property (p_ring) else $error("ring end not loaded");
  property p_ldma;
    host_wr_i && sel == 6'h21 && !core_i.local_dma_load
      |=> cfg_o.local_dma_pos_lo == $past(host_wdata_i);
  endproperty
  a_ldma: assert property (p_ldma) else $error("local pos not loaded");
  property p_p2rd;
    rd_only && sel == 6'h21 |=> host_rdata_o == $past(cfg_o.ring_first_page);
  endproperty
  a_p2rd: assert property (p_p2rd) else $error("ring start misread");
  property p_cfgro;
    host_wr_i && pg == 2'h2 && reg_index_lines_i[3:2] == 2'h3 |=> $stable(
      {cfg_o.rx_config, cfg_o.tx_config, cfg_o.data_config, cfg_o.irq_mask});
  endproperty
  a_cfgro: assert property (p_cfgro) else $error("config changed");
  property p_rnext;
    host_wr_i && sel == 6'h23 ##1 rd_only && sel == 6'h23
      |=> host_rdata_o == $past(host_wdata_i, 2);
  endproperty
  a_rnext: assert property (p_rnext) else $error("next ptr misread");
  property p_rx_write_page;
    host_wr_i && sel == 6'h17 |=> cfg_o.rx_write_page == $past(host_wdata_i);
  endproperty
  a_rx_write_page: assert property (p_rx_write_page) else $error("write page wrong");
  property p_hash;
    host_wr_i && sel == 6'h18
      |=> multicast_hash_bytes_o[7:0] == $past(host_wdata_i);
  endproperty
  a_hash: assert property (p_hash) else $error("hash byte wrong");
  property p_cmd;
    host_wr_i && reg_index_lines_i == 4'h0
      |=> cfg_o.command_register == $past(host_wdata_i);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command not loaded");
  property p_rsvd;
    rd_only && sel == 6'h0a && quiet |=> $stable(cfg_o);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read disturbs");
endmodule

bind prd_paged_register_decode prd_paged_register_decode_props #(
  .HASH_BYTES(HASH_BYTES)
) u_props (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .host_rd_i(host_rd_i),
  .host_wr_i(host_wr_i), .reg_index_lines_i(reg_index_lines_i),
  .host_wdata_i(host_wdata_i), .core_i(core_i), .host_rdata_o(host_rdata_o),
  .host_rvalid_o(host_rvalid_o), .cfg_o(cfg_o),
  .multicast_hash_bytes_o(multicast_hash_bytes_o));

//--- prd_host_model.sv
/*
 * Host processor model driving the register strobes.
 * Assumes it starts in step with the decoder's reset page and stop bit.
 */
`timescale 1ns/1ps
module prd_host_model (
  input wire logic mclk_i, // Clock.
  output logic host_rd_o, // Read strobe.
  output logic host_wr_o, // Write strobe.
  output logic [3:0] idx_o, // Location.
  output logic [7:0] wdata_o // Write byte.
);
  logic [1:0] pg = 2'h0;
  logic stop = 1'b1;
  // Idle lines at time zero.
  initial begin
    host_rd_o = 1'b0;
    host_wr_o = 1'b0;
    idx_o = 4'h0;
    wdata_o = 8'h00;
  end
  // One access launched at the next rising edge, one cycle wide.
  task automatic acc(input logic r, input logic w, input logic [3:0] i,
                     input logic [7:0] d);
    if (w && i != 4'h0 && (pg == 2'h3 || (pg == 2'h2 && !stop))) w = 1'b0;
    if (w && i == 4'h0) begin
      pg = d[7:6];
      stop = d[0];
    end
    @(posedge mclk_i);
    host_rd_o <= r;
    host_wr_o <= w;
    idx_o <= i;
    wdata_o <= w ? d : ~wdata_o;
  endtask
  // Released lines flip so a stale value is never mistaken for data.
  task automatic idle();
    @(posedge mclk_i);
    host_rd_o <= 1'b0;
    host_wr_o <= 1'b0;
    idx_o <= ~idx_o;
    wdata_o <= ~wdata_o;
  endtask
endmodule

//--- prd_paged_register_decode_test.sv
/*
 * Self-checking bench for the paged register decoder.
 * Assumes the host model drives strobes and reads answer one cycle later.
 */
`timescale 1ns/1ps
module prd_paged_register_decode_test;
  logic mclk_i, reset_n_i, rd, wr, rvalid;
  logic [3:0] idx;
  logic [7:0] wd, rdata, b, d, e;
  prd_pkg::prd_core_stat_t core;
  prd_pkg::prd_cfg_t cfg;
  logic [47:0] sta;
  logic [63:0] hsh;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] exp_q[$];
  logic [7:0] p1[16];
  logic [7:0] v[9];
  logic [7:0] c[4];
  logic [3:0] loc[9] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf};

  // Free-running clock.
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  prd_host_model host (.mclk_i(mclk_i), .host_rd_o(rd), .host_wr_o(wr),
    .idx_o(idx), .wdata_o(wd));
  prd_paged_register_decode DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .host_rd_i(rd), .host_wr_i(wr), .reg_index_lines_i(idx),
    .host_wdata_i(wd), .core_i(core), .host_rdata_o(rdata),
    .host_rvalid_o(rvalid), .cfg_o(cfg), .station_addr_bytes_o(sta),
    .multicast_hash_bytes_o(hsh));

  task automatic check(input logic [183:0] seen, input logic [183:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task w(input logic [3:0] i, input logic [7:0] x);
    host.acc(1'b0, 1'b1, i, x);
  endtask
  // The expected byte is noted before the read is launched.
  task r(input logic [3:0] i, input logic [7:0] x);
    exp_q.push_back(x);
    host.acc(1'b1, 1'b0, i, 8'h00);
  endtask
  task settle();
    host.idle();
    @(negedge mclk_i);
  endtask

  // Each read answer is matched with the oldest noted byte.
  always @(negedge mclk_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() > 0)
        check(rdata, exp_q.pop_front());
      else
        check(1'b1, 1'b0);
    end
  end
  // A hang is cut off well past the expected hundred or so cycles.
  initial begin
    repeat (4000) @(posedge mclk_i);
    error_cnt++;
    summarize();
  end

  initial begin
    reset_n_i = 1'b0;
    core = '0;
    void'($urandom(32'h7c44));
    for (int k = 0; k < 9; k++) v[k] = $urandom;
    for (int k = 0; k < 4; k++) c[k] = $urandom;
    b = $urandom;
    d = $urandom;
    e = $urandom;
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    core <= {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7], v[8],
             8'h00, 1'b0, 8'h00, 8'h00};
    @(negedge mclk_i);
    check(cfg, {8'h01, 176'h0});
    check(sta | hsh, 64'h0);
    // Page 0 live values, reserved read and write-side loads.
    for (int k = 0; k < 9; k++) r(loc[k], v[k]);
    r(4'ha, 8'h00);
    r(4'h0, 8'h01);
    w(4'h1, b);
    w(4'h2, ~b);
    for (int k = 0; k < 4; k++) w(4'hc + k, c[k]);
    r(4'h1, 8'h00);
    settle();
    check({cfg.ring_first_page, cfg.ring_last_page}, {b, ~b});
    // Page 2 taken by the very next access after the command write.
    w(4'h0, 8'h81);
    r(4'h1, b);
    r(4'h2, ~b);
    w(4'h1, d);
    w(4'h2, ~d);
    w(4'h3, e);
    r(4'h3, e);
    w(4'hc, ~c[0]);
    for (int k = 0; k < 4; k++) r(4'hc + k, c[k]);
    settle();
    check({cfg.local_dma_pos_lo, cfg.local_dma_pos_hi}, {d, ~d});
    w(4'h0, 8'h01);
    r(4'h1, d);
    r(4'h2, ~d);
    // Page 1 station, write-page and hash bytes.
    w(4'h0, 8'h41);
    for (int i = 1; i < 16; i++) begin
      p1[i] = $urandom;
      w(i[3:0], p1[i]);
    end
    for (int i = 1; i < 16; i++) r(i[3:0], p1[i]);
    settle();
    check(sta, {p1[6], p1[5], p1[4], p1[3], p1[2], p1[1]});
    check(hsh, {p1[15], p1[14], p1[13], p1[12], p1[11], p1[10], p1[9],
                p1[8]});
    check(cfg.rx_write_page, p1[7]);
    // Page 3 reads nothing but the command, which leads back out.
    w(4'h0, 8'hc1);
    r(4'h5, 8'h00);
    r(4'h0, 8'hc1);
    w(4'h0, 8'h01);
    r(4'h7, 8'h00);
    settle();
    // Core events: a status set and a position load, one cycle each.
    @(posedge mclk_i);
    core.irq_set <= b;
    core.local_dma_load <= 1'b1;
    core.local_dma_lo <= e;
    core.local_dma_hi <= ~e;
    @(posedge mclk_i);
    core.irq_set <= 8'h00;
    core.local_dma_load <= 1'b0;
    r(4'h7, b);
    r(4'h1, e);
    r(4'h2, ~e);
    // A core set in the same cycle as a host clear must survive.
    w(4'h7, 8'hff);
    core.irq_set <= 8'h01;
    host.idle();
    core.irq_set <= 8'h00;
    r(4'h7, 8'h01);
    settle();
    repeat (2) @(negedge mclk_i);
    check(exp_q.size(), 0);
    summarize();
  end
endmodule
